//--- common/dma_pkg.sv
// Constants, types and helper functions of the four-channel DMA controller
`default_nettype none
package dma_pkg;
  // ****************************************
  // Structure
  // ****************************************
  localparam int NUM_CH = 4;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_REQ  = 4'h2,
    S_RD   = 4'h4,
    S_WR   = 4'h8
  } eng_state_t;

  typedef struct packed {
    logic [1:0] unitWidth;
    logic [1:0] dstStepDir;
    logic [1:0] srcStepDir;
    logic       dstIo;
    logic       srcIo;
    logic       releaseHonor;
    logic       snoopSelect;
    logic       externalTriggerSel;
    logic       start;
  } chan_ctrl_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  size;
    logic        read;
    logic        write;
  } mem_req_t;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_SRC    = 5'h08;
  localparam logic [4:0] OFF_DST    = 5'h0C;
  localparam logic [4:0] OFF_COUNT  = 5'h10;
  localparam logic [4:0] OFF_STEP   = 5'h14;
  localparam logic [7:0] ADDR_HOLD  = 8'h80;
  localparam int STAT_ACTIVE_POS = 31;
  localparam int STAT_DONE_POS   = 23;
  localparam int STAT_CONF_POS   = 18;
  localparam int SRC_SEL_POS     = 0;
  localparam int DST_SEL_POS     = 3;
  localparam logic [2:0]  SEL_MAX   = 3'h4;
  localparam logic [1:0]  W_BYTE    = 2'h3;
  localparam logic [1:0]  W_HALF    = 2'h2;
  localparam logic [31:0] PTR_RST   = 32'h0;
  localparam logic [23:0] COUNT_RST = 24'h0;
  localparam logic [5:0]  STEP_RST  = 6'h0;
  localparam logic [11:0] CTRL_RST  = 12'h000;

  // ****************************************
  // Arithmetic
  // ****************************************
  function automatic logic [2:0] unitBytes(input logic [1:0] w);
    unitBytes = (w == W_BYTE) ? 3'h1 : (w == W_HALF) ? 3'h2 : 3'h4;
  endfunction : unitBytes

  function automatic logic [31:0] stepPtr(input logic [31:0] p,
                                          input logic [1:0]  dir,
                                          input logic [2:0]  sel,
                                          input logic [1:0]  w);
    logic [31:0] amt;
    amt = (sel == 3'h0) ? {29'h0, unitBytes(w)}
                        : (32'h1 << {sel, 2'b00});
    if (dir[1]) stepPtr = p;
    else if (dir[0]) stepPtr = p - amt;
    else stepPtr = p + amt;
  endfunction : stepPtr
endpackage : dma_pkg
`default_nettype wire

//--- src/dual_address_dma_channel.sv
// Four-channel dual-address DMA engine with Avalon-MM register slave
`default_nettype none
module dual_address_dma_channel (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic [7:0]                avAddress,
  input  wire logic                      avRead,
  input  wire logic                      avWrite,
  input  wire logic [31:0]               avWritedata,
  output var  logic [31:0]               avReaddata,
  output      logic                      avWaitrequest,
  output      dma_pkg::mem_req_t         memReq,
  input  wire logic [31:0]               memRdata,
  input  wire logic                      memReady,
  input  wire logic                      busGrant,
  input  wire logic                      busReleaseReq,
  output      logic                      plainBusRequest,
  output      logic                      snoopBusRequest,
  input  wire logic [dma_pkg::NUM_CH-1:0] dmaRequestIn_n,
  output var  logic [dma_pkg::NUM_CH-1:0] dmaAckOut_n
);
  // ****************************************
  // Storage
  // ****************************************
  dma_pkg::eng_state_t  state;
  dma_pkg::eng_state_t  next_state;
  logic [1:0]           curCh;
  logic [1:0]           next_curCh;
  dma_pkg::chan_ctrl_t  ctrl    [dma_pkg::NUM_CH];
  logic [31:0]          srcPtr  [dma_pkg::NUM_CH];
  logic [31:0]          dstPtr  [dma_pkg::NUM_CH];
  logic [23:0]          count   [dma_pkg::NUM_CH];
  logic [5:0]           stepSel [dma_pkg::NUM_CH];
  logic [dma_pkg::NUM_CH-1:0] active;
  logic [dma_pkg::NUM_CH-1:0] done;
  logic [dma_pkg::NUM_CH-1:0] confErr;
  logic [dma_pkg::NUM_CH-1:0] armed;
  logic [31:0]          holdBuffer;
  logic                 avAck;

  // ****************************************
  // Bus slave decode
  // ****************************************
  logic                       inChan;
  logic [1:0]                 selCh;
  logic [4:0]                 regOff;
  logic                       swWrite;
  logic [dma_pkg::NUM_CH-1:0] hitCh;
  logic [dma_pkg::NUM_CH-1:0] badStart;
  logic [31:0]                ctrlWord;
  logic [31:0]                statWord;
  logic [31:0]                chanWord;
  logic [31:0]                rdValue;

  assign inChan        = !avAddress[7];
  assign selCh         = avAddress[6:5];
  assign regOff        = avAddress[4:0];
  assign avWaitrequest = (avRead || avWrite) && !avAck;
  assign swWrite       = avWrite && avAck;

  function automatic logic [1:0] firstSet(input logic [3:0] v);
    firstSet = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction : firstSet

  function automatic logic cfgBad(input dma_pkg::chan_ctrl_t c,
                                  input logic [5:0]  s,
                                  input logic [23:0] n,
                                  input logic        d);
    cfgBad = (c.srcIo && c.dstIo)
          || (s[2:0] > dma_pkg::SEL_MAX)
          || (s[5:3] > dma_pkg::SEL_MAX)
          || (!c.externalTriggerSel && (c.srcIo || c.dstIo))
          || (n == 24'h0) || d;
  endfunction : cfgBad

  for (genvar g = 0; g < dma_pkg::NUM_CH; g++) begin : g_dec
    assign hitCh[g]    = swWrite && inChan && (selCh == 2'(g));
    assign badStart[g] = cfgBad(dma_pkg::chan_ctrl_t'(avWritedata[11:0]),
                                stepSel[g], count[g], done[g]);
  end

  assign ctrlWord = {20'h0, ctrl[selCh][11:1], active[selCh]};
  assign statWord = (32'(active[selCh])  << dma_pkg::STAT_ACTIVE_POS)
                  | (32'(done[selCh])    << dma_pkg::STAT_DONE_POS)
                  | (32'(confErr[selCh]) << dma_pkg::STAT_CONF_POS);
  assign chanWord = (regOff == dma_pkg::OFF_CTRL)   ? ctrlWord
                  : (regOff == dma_pkg::OFF_STATUS) ? statWord
                  : (regOff == dma_pkg::OFF_SRC)    ? srcPtr[selCh]
                  : (regOff == dma_pkg::OFF_DST)    ? dstPtr[selCh]
                  : (regOff == dma_pkg::OFF_COUNT)  ? {8'h0, count[selCh]}
                  : (regOff == dma_pkg::OFF_STEP)   ? {26'h0, stepSel[selCh]}
                  : 32'h0;
  assign rdValue  = inChan ? chanWord
                  : (avAddress == dma_pkg::ADDR_HOLD) ? holdBuffer : 32'h0;

  // ****************************************
  // Engine decode
  // ****************************************
  logic [dma_pkg::NUM_CH-1:0] pending;
  logic [dma_pkg::NUM_CH-1:0] keepMask;
  logic [dma_pkg::NUM_CH-1:0] pendAfter;
  dma_pkg::chan_ctrl_t        curCtrl;
  logic [2:0]                 curUnit;
  logic [23:0]                curCount;
  logic                       lastXfer;
  logic                       curIo;
  logic                       rdDone;
  logic                       wrDone;
  logic                       releaseNow;
  logic                       busBusy;
  logic [31:0]                nextSrc;
  logic [31:0]                nextDst;

  // Armed blocks a stale low level right after an acknowledge
  for (genvar g = 0; g < dma_pkg::NUM_CH; g++) begin : g_pend
    assign pending[g] = active[g] && (!ctrl[g].externalTriggerSel
                     || (!dmaRequestIn_n[g] && armed[g]));
  end

  assign curCtrl    = ctrl[curCh];
  assign curUnit    = dma_pkg::unitBytes(curCtrl.unitWidth);
  assign curCount   = count[curCh];
  assign lastXfer   = curCount <= {21'h0, curUnit};
  assign curIo      = curCtrl.srcIo || curCtrl.dstIo;
  assign rdDone     = (state == dma_pkg::S_RD) && memReady;
  assign wrDone     = (state == dma_pkg::S_WR) && memReady;
  assign keepMask   = (lastXfer || curIo) ? ~(4'h1 << curCh) : 4'hF;
  assign pendAfter  = pending & keepMask;
  assign releaseNow = busReleaseReq && curCtrl.releaseHonor
                   && !curCtrl.snoopSelect;
  assign busBusy    = state != dma_pkg::S_IDLE;
  assign nextSrc    = dma_pkg::stepPtr(srcPtr[curCh], curCtrl.srcStepDir,
                        stepSel[curCh][dma_pkg::SRC_SEL_POS +: 3],
                        curCtrl.unitWidth);
  assign nextDst    = dma_pkg::stepPtr(dstPtr[curCh], curCtrl.dstStepDir,
                        stepSel[curCh][dma_pkg::DST_SEL_POS +: 3],
                        curCtrl.unitWidth);

  assign plainBusRequest = busBusy && !curCtrl.snoopSelect;
  assign snoopBusRequest = busBusy && curCtrl.snoopSelect;
  // Address is a mux of registered pointers; write data is the buffer
  assign memReq = {(state == dma_pkg::S_RD) ? srcPtr[curCh] : dstPtr[curCh],
                   holdBuffer, curCtrl.unitWidth,
                   state == dma_pkg::S_RD, state == dma_pkg::S_WR};

  always_comb begin
    next_state = state;
    next_curCh = curCh;
    case (state)
      dma_pkg::S_IDLE: begin
        if (|pending) begin
          next_state = dma_pkg::S_REQ;
          next_curCh = firstSet(pending);
        end
      end
      dma_pkg::S_REQ: begin
        if (busGrant) next_state = dma_pkg::S_RD;
      end
      dma_pkg::S_RD: begin
        if (memReady) next_state = dma_pkg::S_WR;
      end
      dma_pkg::S_WR: begin
        if (memReady) begin
          if (releaseNow || (pendAfter == 4'h0)) begin
            next_state = dma_pkg::S_IDLE;
          end else begin
            next_state = dma_pkg::S_RD;
            next_curCh = firstSet(pendAfter);
          end
        end
      end
      default: next_state = dma_pkg::S_IDLE;
    endcase
  end

  // ****************************************
  // Engine and slave registers
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state      <= dma_pkg::S_IDLE;
      curCh      <= 2'h0;
      holdBuffer <= 32'h0;
      avAck      <= 1'b0;
      avReaddata <= 32'h0;
    end else begin
      state <= next_state;
      curCh <= next_curCh;
      avAck <= (avRead || avWrite) && !avAck;
      if (rdDone) holdBuffer <= memRdata;
      if (avRead && !avAck) avReaddata <= rdValue;
    end
  end

  // ****************************************
  // Per-channel state
  // ****************************************
  // Pointers and count ignore software while the channel is running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
        ctrl[i]        <= dma_pkg::CTRL_RST;
        srcPtr[i]      <= dma_pkg::PTR_RST;
        dstPtr[i]      <= dma_pkg::PTR_RST;
        count[i]       <= dma_pkg::COUNT_RST;
        stepSel[i]     <= dma_pkg::STEP_RST;
        active[i]      <= 1'b0;
        done[i]        <= 1'b0;
        confErr[i]     <= 1'b0;
        armed[i]       <= 1'b1;
        dmaAckOut_n[i] <= 1'b1;
      end
    end else begin
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
        if (hitCh[i] && regOff == dma_pkg::OFF_CTRL) begin
          ctrl[i] <= avWritedata[11:0];
          if (!avWritedata[0]) active[i] <= 1'b0;
          else if (!active[i] && badStart[i]) confErr[i] <= 1'b1;
          else if (!active[i]) active[i] <= 1'b1;
        end
        if (hitCh[i] && regOff == dma_pkg::OFF_STATUS) begin
          if (!avWritedata[dma_pkg::STAT_DONE_POS]) done[i] <= 1'b0;
          if (!avWritedata[dma_pkg::STAT_CONF_POS]) confErr[i] <= 1'b0;
        end
        if (!active[i]) begin
          if (hitCh[i] && regOff == dma_pkg::OFF_SRC) srcPtr[i] <= avWritedata;
          if (hitCh[i] && regOff == dma_pkg::OFF_DST) dstPtr[i] <= avWritedata;
          if (hitCh[i] && regOff == dma_pkg::OFF_COUNT)
            count[i] <= avWritedata[23:0];
          if (hitCh[i] && regOff == dma_pkg::OFF_STEP)
            stepSel[i] <= avWritedata[5:0];
        end
        if (dmaRequestIn_n[i]) armed[i] <= 1'b1;
        dmaAckOut_n[i] <= 1'b1;
        if (wrDone && curCh == 2'(i)) begin
          srcPtr[i] <= nextSrc;
          dstPtr[i] <= nextDst;
          count[i]  <= lastXfer ? 24'h0 : curCount - {21'h0, curUnit};
          if (curIo) armed[i] <= 1'b0;
          dmaAckOut_n[i] <= !(curIo || lastXfer);
          if (lastXfer) begin
            active[i] <= 1'b0;
            done[i]   <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_ack_io;
    @(posedge clk) disable iff (!rstn)
    (wrDone && curIo) |=> !dmaAckOut_n[$past(curCh)];
  endproperty
  a_ack_io: assert property (p_ack_io) else $error("io ack missing");

  property p_no_early_ack;
    @(posedge clk) disable iff (!rstn)
    (wrDone && !curIo && !lastXfer) |=> (dmaAckOut_n == 4'hF);
  endproperty
  a_no_early_ack: assert property (p_no_early_ack)
    else $error("mem ack before zero");

  property p_grant_first;
    @(posedge clk) disable iff (!rstn)
    (state == dma_pkg::S_REQ && !busGrant) |=> !memReq.read && !memReq.write;
  endproperty
  a_grant_first: assert property (p_grant_first)
    else $error("bus used without grant");

  property p_one_request;
    @(posedge clk) disable iff (!rstn)
    !(plainBusRequest && snoopBusRequest)
      && (busBusy == (plainBusRequest || snoopBusRequest));
  endproperty
  a_one_request: assert property (p_one_request)
    else $error("bus request lines wrong");

  property p_read_then_write;
    @(posedge clk) disable iff (!rstn)
    rdDone |=> memReq.write && !memReq.read
      && memReq.wdata == $past(memRdata);
  endproperty
  a_read_then_write: assert property (p_read_then_write)
    else $error("write does not follow read");

  property p_count_step;
    @(posedge clk) disable iff (!rstn)
    (wrDone && !lastXfer) |=>
      count[$past(curCh)] == $past(curCount) - {21'h0, $past(curUnit)};
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count step wrong");

  property p_release;
    @(posedge clk) disable iff (!rstn)
    (wrDone && releaseNow) |=> state == dma_pkg::S_IDLE;
  endproperty
  a_release: assert property (p_release)
    else $error("release not honoured");

  property p_idle_free;
    @(posedge clk) disable iff (!rstn)
    (wrDone && (pendAfter == 4'h0))
      |=> !plainBusRequest && !snoopBusRequest;
  endproperty
  a_idle_free: assert property (p_idle_free)
    else $error("bus held with nothing pending");

  property p_no_io_pair;
    @(posedge clk) disable iff (!rstn)
    $rose(active[3]) |-> !(ctrl[3].srcIo && ctrl[3].dstIo);
  endproperty
  a_no_io_pair: assert property (p_no_io_pair)
    else $error("io to io started");

  property p_internal_go;
    @(posedge clk) disable iff (!rstn)
    (state == dma_pkg::S_IDLE && active[0] && !ctrl[0].externalTriggerSel)
      |=> state == dma_pkg::S_REQ;
  endproperty
  a_internal_go: assert property (p_internal_go)
    else $error("internal start stalled");

  // A level still low after acknowledge must not start a second unit
  property p_rearm;
    @(posedge clk) disable iff (!rstn)
    (wrDone && curIo) |=> !pending[$past(curCh)];
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("stale request restarted");

  property p_fixed_dst;
    @(posedge clk) disable iff (!rstn)
    (wrDone && curCtrl.dstStepDir[1])
      |=> dstPtr[$past(curCh)] == $past(dstPtr[curCh]);
  endproperty
  a_fixed_dst: assert property (p_fixed_dst)
    else $error("fixed pointer moved");

  c_mem_done: cover property (@(posedge clk) disable iff (!rstn)
    wrDone && lastXfer && !curIo);
  c_io_ack: cover property (@(posedge clk) disable iff (!rstn)
    wrDone && curIo && !lastXfer);
  c_release: cover property (@(posedge clk) disable iff (!rstn)
    wrDone && releaseNow && (pendAfter != 4'h0));
  c_snoop_keep: cover property (@(posedge clk) disable iff (!rstn)
    wrDone && busReleaseReq && curCtrl.snoopSelect && !lastXfer);
endmodule : dual_address_dma_channel
`default_nettype wire

//--- bench/dma_far_side.sv
// Far-side model: memory, bus arbiter and request source
`default_nettype none
module dma_far_side (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire dma_pkg::mem_req_t memReq,
  input  wire logic              plainBusRequest,
  input  wire logic              snoopBusRequest,
  input  wire logic [3:0]        dmaAckOut_n,
  input  wire logic [3:0]        raise,
  input  wire logic              slow,
  output logic [31:0]            memRdata,
  output logic                   memReady,
  output logic                   busGrant,
  output logic [3:0]             dmaRequestIn_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // State
  // ****************
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  waitCnt;
  logic        reqSeen;
  wire logic   anyReq = plainBusRequest | snoopBusRequest;
  wire logic   busy   = memReq.read | memReq.write;
  wire logic [1:0] lat = slow ? 2'h3 : 2'h0;

  // ****************
  // Arbiter and request source
  // ****************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busGrant       <= 1'h0;
      reqSeen        <= 1'h0;
      dmaRequestIn_n <= 4'hF;
    end else begin
      reqSeen  <= anyReq;
      busGrant <= anyReq & (~slow | reqSeen);
      // Level held low until acknowledged, then withdrawn
      dmaRequestIn_n <= (dmaRequestIn_n | ~dmaAckOut_n) & ~raise;
    end
  end

  // ****************
  // Memory
  // ****************
  // Idle data toggles so a stale sample never looks right
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memReady <= 1'h0;
      waitCnt  <= 2'h0;
      memRdata <= 32'h5A5A_5A5A;
    end else if (memReady || !busy) begin
      memReady <= 1'h0;
      waitCnt  <= 2'h0;
      memRdata <= ~memRdata;
    end else if (waitCnt != lat) begin
      waitCnt <= waitCnt + 2'h1;
    end else begin
      memReady <= 1'h1;
      if (memReq.write) mem[memReq.addr] = memReq.wdata;
      memRdata <= mem.exists(memReq.addr) ? mem[memReq.addr] : ~memReq.addr;
    end
  end
endmodule : dma_far_side
`default_nettype wire

//--- bench/dual_address_dma_channel_tb.sv
// Self-checking bench for the dual-address DMA engine
`default_nettype none
module dual_address_dma_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Signals
  // ****************
  logic              clk;
  logic              rstn;
  logic [7:0]        avAddress;
  logic              avRead;
  logic              avWrite;
  logic [31:0]       avWritedata;
  logic [31:0]       avReaddata;
  logic              avWaitrequest;
  dma_pkg::mem_req_t memReq;
  logic [31:0]       memRdata;
  logic              memReady;
  logic              busGrant;
  logic              busReleaseReq;
  logic              plainBusRequest;
  logic              snoopBusRequest;
  logic [3:0]        dmaRequestIn_n;
  logic [3:0]        dmaAckOut_n;
  logic [3:0]        raise;
  logic              slow;
  logic [31:0]       rd;
  logic [1:0]        lastSize;
  logic              prevReq = 1'h0;
  logic              sawPlain = 1'h0;
  logic              sawSnoop = 1'h0;
  int                falls;
  int                ackCnt [4];
  int                errors = 0;
  int                numChecks = 0;
  logic [1:0]        wTab [5] = '{2'h3, 2'h2, 2'h0, 2'h1, 2'h3};

  dual_address_dma_channel dut (
    .clk(clk), .rstn(rstn), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWritedata(avWritedata),
    .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
    .memReq(memReq), .memRdata(memRdata), .memReady(memReady),
    .busGrant(busGrant), .busReleaseReq(busReleaseReq),
    .plainBusRequest(plainBusRequest), .snoopBusRequest(snoopBusRequest),
    .dmaRequestIn_n(dmaRequestIn_n), .dmaAckOut_n(dmaAckOut_n));

  dma_far_side far (
    .clk(clk), .rstn(rstn), .memReq(memReq),
    .plainBusRequest(plainBusRequest), .snoopBusRequest(snoopBusRequest),
    .dmaAckOut_n(dmaAckOut_n), .raise(raise), .slow(slow),
    .memRdata(memRdata), .memReady(memReady), .busGrant(busGrant),
    .dmaRequestIn_n(dmaRequestIn_n));

  always #25 clk = ~clk;

  // ****************
  // Monitors
  // ****************
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) if (dmaAckOut_n[i] === 1'h0) ackCnt[i]++;
    if (prevReq && !(plainBusRequest | snoopBusRequest)) falls++;
    prevReq = plainBusRequest | snoopBusRequest;
    sawPlain |= plainBusRequest;
    sawSnoop |= snoopBusRequest;
    if (memReq.write) lastSize = memReq.size;
  end

  // ****************
  // Tasks
  // ****************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task end_sim;
    if (errors == 0 && numChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  function automatic logic [7:0] regAddr(input logic [2:0] ch,
                                         input logic [4:0] off);
    regAddr = {ch, off};
  endfunction : regAddr

  // Request held until waitrequest is seen low at an edge
  task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avAddress   <= a;
    avWritedata <= d;
    avWrite     <= wr;
    avRead      <= ~wr;
    // No fixed latency assumed; only the watchdog ends a hung access
    do @(posedge clk);
    while (avWaitrequest !== 1'h0);
    rd = avReaddata;
    avRead  <= 1'h0;
    avWrite <= 1'h0;
  endtask : av

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    av(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task prog(input logic [2:0] ch, input logic [11:0] ctrl,
            input logic [31:0] src, input logic [31:0] dst,
            input logic [31:0] cnt, input logic [5:0] step);
    falls = 0;
    sawPlain = 1'h0;
    sawSnoop = 1'h0;
    foreach (ackCnt[i]) ackCnt[i] = 0;
    av(1'h1, regAddr(ch, dma_pkg::OFF_STATUS), 32'h0);
    av(1'h1, regAddr(ch, dma_pkg::OFF_SRC), src);
    av(1'h1, regAddr(ch, dma_pkg::OFF_DST), dst);
    av(1'h1, regAddr(ch, dma_pkg::OFF_COUNT), cnt);
    av(1'h1, regAddr(ch, dma_pkg::OFF_STEP), {26'h0, step});
    av(1'h1, regAddr(ch, dma_pkg::OFF_CTRL), {20'h0, ctrl});
  endtask : prog

  task waitDone(input logic [2:0] ch);
    int i;
    for (i = 0; i < 400; i++) begin
      av(1'h0, regAddr(ch, dma_pkg::OFF_STATUS), 32'h0);
      if (rd[dma_pkg::STAT_DONE_POS] === 1'h1) break;
    end
    chk(32'(rd[dma_pkg::STAT_DONE_POS]), 32'h1);
  endtask : waitDone

  task irq(input int ch, input int n);
    int i;
    @(posedge clk);
    raise <= 4'(1 << ch);
    @(posedge clk);
    raise <= 4'h0;
    for (i = 0; i < 100 && ackCnt[ch] < n; i++) @(posedge clk);
  endtask : irq

  // ****************
  // Tests
  // ****************
  initial begin
    logic [31:0] amt;
    logic [1:0]  dd;
    int          b;
    clk = 1'h0; rstn = 1'h0; avAddress = 8'h0; avRead = 1'h0;
    avWrite = 1'h0; avWritedata = 32'h0; busReleaseReq = 1'h0;
    raise = 4'h0; slow = 1'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    // Reset values, unmapped place and read-only buffer
    for (int o = 0; o < 24; o += 4) rdchk({3'h0, 5'(o)}, 32'h0);
    av(1'h1, 8'h1C, 32'hFFFF_FFFF);
    rdchk(8'h1C, 32'h0);
    av(1'h1, dma_pkg::ADDR_HOLD, 32'hFFFF_FFFF);
    rdchk(dma_pkg::ADDR_HOLD, 32'h0);
    // Internal word block, one request moves all
    far.mem[32'h100] = 32'h1111_2222;
    far.mem[32'h104] = 32'h3333_4444;
    prog(3'h0, 12'h001, 32'h100, 32'h200, 32'h8, 6'h0);
    waitDone(3'h0);
    chk(far.mem[32'h200], 32'h1111_2222);
    chk(far.mem[32'h204], 32'h3333_4444);
    rdchk(regAddr(3'h0, dma_pkg::OFF_DST), 32'h208);
    rdchk(regAddr(3'h0, dma_pkg::OFF_COUNT), 32'h0);
    rdchk(dma_pkg::ADDR_HOLD, 32'h3333_4444);
    chk(32'(ackCnt[0]), 32'h1);
    chk(32'(falls), 32'h1);
    chk(32'(sawSnoop), 32'h0);
    // Every width and step bit, snooping request
    for (int k = 0; k < 5; k++) begin
      b = (wTab[k] == 2'h3) ? 1 : (wTab[k] == 2'h2) ? 2 : 4;
      amt = (k == 0) ? 32'(b) : 32'h1 << (4 * k);
      dd = (k == 4) ? 2'h2 : 2'h1;
      prog(3'h1, {wTab[k], dd, 8'h05}, 32'h1000, 32'h8000, 32'(2 * b),
           {3'(k), 3'(k)});
      waitDone(3'h1);
      rdchk(regAddr(3'h1, dma_pkg::OFF_SRC), 32'h1000 + 2 * amt);
      rdchk(regAddr(3'h1, dma_pkg::OFF_DST),
            (k == 4) ? 32'h8000 : 32'h8000 - 2 * amt);
      rdchk(regAddr(3'h1, dma_pkg::OFF_COUNT), 32'h0);
      chk({30'h0, sawSnoop, sawPlain}, 32'h2);
      chk(32'(lastSize), 32'(wTab[k]));
    end
    // Reserved step codes refused
    foreach (wTab[j]) if (j < 2) begin
      prog(3'h1, 12'h001, 32'h0, 32'h0, 32'h4, j ? 6'h28 : 6'h05);
      av(1'h0, regAddr(3'h1, dma_pkg::OFF_STATUS), 32'h0);
      chk(32'(rd[dma_pkg::STAT_CONF_POS]), 32'h1);
    end
    // Peripheral source, one unit per request
    far.mem[32'h40] = 32'h0000_00AB;
    prog(3'h2, 12'hC93, 32'h40, 32'h300, 32'h2, 6'h0);
    repeat (20) @(posedge clk);
    chk(32'(sawPlain | sawSnoop), 32'h0);
    irq(2, 1);
    rdchk(regAddr(3'h2, dma_pkg::OFF_COUNT), 32'h1);
    av(1'h0, regAddr(3'h2, dma_pkg::OFF_STATUS), 32'h0);
    chk(32'(rd[dma_pkg::STAT_ACTIVE_POS]), 32'h1);
    chk(32'(ackCnt[2]), 32'h1);
    irq(2, 2);
    waitDone(3'h2);
    chk(32'(ackCnt[2]), 32'h2);
    rdchk(regAddr(3'h2, dma_pkg::OFF_DST), 32'h302);
    rdchk(regAddr(3'h2, dma_pkg::OFF_SRC), 32'h40);
    // Peripheral at both ends refused
    prog(3'h3, 12'h033, 32'h0, 32'h0, 32'h4, 6'h0);
    av(1'h0, regAddr(3'h3, dma_pkg::OFF_STATUS), 32'h0);
    chk({rd[dma_pkg::STAT_ACTIVE_POS], rd[dma_pkg::STAT_CONF_POS]},
        32'h1);
    // Release honoured on plain request only, slow far side
    far.mem[32'h400] = 32'hCAFE_0001;
    far.mem[32'h404] = 32'hCAFE_0002;
    busReleaseReq <= 1'h1;
    slow <= 1'h1;
    for (int s = 0; s < 2; s++) begin
      prog(3'h3, s ? 12'h00D : 12'h009, 32'h400, 32'h500, 32'h8, 6'h0);
      waitDone(3'h3);
      chk(32'(falls), s ? 32'h1 : 32'h2);
      chk(far.mem[32'h504], 32'hCAFE_0002);
      chk(32'(ackCnt[3]), 32'h1);
    end
    end_sim();
  end

  // Generous bound: all tests need a few hundred cycles
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule : dual_address_dma_channel_tb
`default_nettype wire
